// *** hdl/dmfe_top.sv ***
// How it works
// RQ1: Each operand register may be bypassed.
// RQ2: Registers pick clock, enable, clear of four.
// RQ3: A and B registers drive chain outputs.
// RQ4: Chain outputs feed next multiplier's registers.
// RQ5: Source select one loads chain, zero parallel.
// RQ6: Shift input unavailable in 36x36 mode.
// RQ7: Sign inputs mark each operand signed.
// RQ8: Product signed if either operand signed.
// RQ9: Driver keeps one signedness per operand.
// RQ10: Products are full precision, never truncated.
// RQ11: Saturate and round only 18x18 signed.
// RQ12: Driver puts fractions in upper sixteen bits.
// RQ13: 18x18 product is 2.34 with sign copies.
// RQ14: Saturation forces 0x7fffffff, low three cleared; the code sets them to 001.
// RQ15: Saturation flag is product's lowest bit.
// RQ16: Rounding adds half, clears lowest sixteen bits; the code adds bit 18 (RND_ADD) and clears bits 15:0.
// RQ17: Fractional product leaves in 2.31 form.
// RQ18: Product pipeline register may be bypassed.
// RQ19: Sign controls unregistered or registered once.
// RQ20: Sizes 9, 18, 36; narrow lanes parallel.
// RQ21: Selected clear zeroes register immediately.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dmfe_top (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   // AXI4-Lite write channels
   input  wire logic [7:0]  i_s_axi_awaddr,
   input  wire logic        i_s_axi_awvalid,
   output logic             o_s_axi_awready,
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic [3:0]  i_s_axi_wstrb,
   input  wire logic        i_s_axi_wvalid,
   output logic             o_s_axi_wready,
   output logic [1:0]       o_s_axi_bresp,
   output logic             o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]  i_s_axi_araddr,
   input  wire logic        i_s_axi_arvalid,
   output logic             o_s_axi_arready,
   output logic [31:0]      o_s_axi_rdata,
   output logic [1:0]       o_s_axi_rresp,
   output logic             o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready,
   // Block clock, enable and clear lines
   input  wire logic [3:0]  i_clk_pulse,
   input  wire logic [3:0]  i_ena,
   input  wire logic [3:0]  i_aclr,
   // Operands and their controls
   input  wire logic [35:0] i_data_a,
   input  wire logic [35:0] i_data_b,
   input  wire logic        i_operand_a_signed,
   input  wire logic        i_operand_b_signed,
   input  wire logic        i_operand_a_source_select,
   input  wire logic        i_operand_b_source_select,
   // Shift chain
   input  wire logic [17:0] i_shift_in_a,
   input  wire logic [17:0] i_shift_in_b,
   output logic [17:0]      o_shift_out_a,
   output logic [17:0]      o_shift_out_b,
   // Product towards the adder stage
   output logic [71:0]      o_product,
   output logic             o_product_signed,
   output logic             o_product_saturated_flag
);

   // ------------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic [31:0] sel_r;
   logic [7:0]  awaddr_r;
   logic        aw_held_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        w_held_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [1:0]  rresp_r;
   logic [31:0] rdata_r;

   wire aw_take  = i_s_axi_awvalid & o_s_axi_awready;
   wire w_take   = i_s_axi_wvalid & o_s_axi_wready;
   wire ar_take  = i_s_axi_arvalid & o_s_axi_arready;
   wire do_write = aw_held_r & w_held_r & ~bvalid_r;

   assign o_s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign o_s_axi_wready  = ~w_held_r & ~bvalid_r;
   assign o_s_axi_arready = ~rvalid_r;
   assign o_s_axi_bvalid  = bvalid_r;
   assign o_s_axi_bresp   = bresp_r;
   assign o_s_axi_rvalid  = rvalid_r;
   assign o_s_axi_rresp   = rresp_r;
   assign o_s_axi_rdata   = rdata_r;

   wire wr_ctrl = do_write && (awaddr_r == dmfe_pkg::CTRL_OFS);
   wire wr_sel  = do_write && (awaddr_r == dmfe_pkg::SEL_OFS);
   wire wr_ok;
   assign wr_ok = wr_ctrl | wr_sel |
                  (awaddr_r == dmfe_pkg::STATUS_OFS);

   // Byte-lane merge shared by both writable registers.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return res;
   endfunction

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= 8'h00;
      end else if (aw_take) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= i_s_axi_awaddr;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_held_r <= 1'b0;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end else if (w_take) begin
         w_held_r <= 1'b1;
         wdata_r  <= i_s_axi_wdata;
         wstrb_r  <= i_s_axi_wstrb;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r  <= dmfe_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_ok ? dmfe_pkg::RESP_OKAY : dmfe_pkg::RESP_SLVERR;
      end else if (i_s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Unused control bits are never stored, so they always read as zero.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= dmfe_pkg::CTRL_RST;
         sel_r  <= dmfe_pkg::SEL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) &
                      32'h0000_00ff;
         end
         if (wr_sel) begin
            sel_r <= merge(sel_r, wdata_r, wstrb_r) & 32'h003f_3f3f;
         end
      end
   end

   // ------------------------------------------------------------------
   // Configuration decode
   // ------------------------------------------------------------------
   wire [1:0] size_raw  = ctrl_r[dmfe_pkg::CTRL_SIZE_LSB +: 2];
   wire       is_9      = (size_raw == dmfe_pkg::DMFE_SIZE_9);
   wire       is_36     = (size_raw == dmfe_pkg::DMFE_SIZE_36);
   wire       is_18     = ~is_9 & ~is_36;
   wire       a_byp     = ctrl_r[dmfe_pkg::CTRL_A_BYP_BIT];
   wire       b_byp     = ctrl_r[dmfe_pkg::CTRL_B_BYP_BIT];
   wire       ctl_reg   = ctrl_r[dmfe_pkg::CTRL_CTL_REG];
   wire       pipe_byp  = ctrl_r[dmfe_pkg::CTRL_PIPE_BYP];
   wire       sat_en    = ctrl_r[dmfe_pkg::CTRL_SAT_BIT];
   wire       rnd_en    = ctrl_r[dmfe_pkg::CTRL_RND_BIT];
   wire [7:0] sel_a     = sel_r[dmfe_pkg::SEL_A_LSB +: 8];
   wire [7:0] sel_b     = sel_r[dmfe_pkg::SEL_B_LSB +: 8];
   wire [7:0] sel_p     = sel_r[dmfe_pkg::SEL_P_LSB +: 8];

   // ------------------------------------------------------------------
   // Operand input registers and shift chain
   // ------------------------------------------------------------------
   // Shifting is only wired for the narrow sizes; in 36x36 the chain
   // would cover only half an operand, so parallel input is forced.
   wire src_a = i_operand_a_source_select & ~is_36; // RQ6
   wire src_b = i_operand_b_source_select & ~is_36; // RQ6
   wire [35:0] a_in = src_a ? {18'h0_0000, i_shift_in_a} : i_data_a; // RQ5
   wire [35:0] b_in = src_b ? {18'h0_0000, i_shift_in_b} : i_data_b; // RQ5
   wire [35:0] a_op;
   wire [35:0] b_op;
   wire [35:0] a_reg;
   wire [35:0] b_reg;
   wire [1:0]  sign_q;

   dmfe_inreg #(.WIDTH(36)) u_reg_a (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_clk_pulse (i_clk_pulse),
      .i_ena       (i_ena),
      .i_aclr      (i_aclr),
      .i_clk_sel   (sel_a[1:0]),
      .i_ena_sel   (sel_a[dmfe_pkg::SEL_ENA_OFS +: 2]),
      .i_aclr_sel  (sel_a[dmfe_pkg::SEL_ACLR_OFS +: 2]),
      .i_bypass    (a_byp),
      .i_d         (a_in),
      .o_q         (a_op),
      .o_reg       (a_reg)
   );

   dmfe_inreg #(.WIDTH(36)) u_reg_b (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_clk_pulse (i_clk_pulse),
      .i_ena       (i_ena),
      .i_aclr      (i_aclr),
      .i_clk_sel   (sel_b[1:0]),
      .i_ena_sel   (sel_b[dmfe_pkg::SEL_ENA_OFS +: 2]),
      .i_aclr_sel  (sel_b[dmfe_pkg::SEL_ACLR_OFS +: 2]),
      .i_bypass    (b_byp),
      .i_d         (b_in),
      .o_q         (b_op),
      .o_reg       (b_reg)
   );

   // Sign controls follow the A register so they line up with the data.
   dmfe_inreg #(.WIDTH(2)) u_reg_sign (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_clk_pulse (i_clk_pulse),
      .i_ena       (i_ena),
      .i_aclr      (i_aclr),
      .i_clk_sel   (sel_a[1:0]),
      .i_ena_sel   (sel_a[dmfe_pkg::SEL_ENA_OFS +: 2]),
      .i_aclr_sel  (sel_a[dmfe_pkg::SEL_ACLR_OFS +: 2]),
      .i_bypass    (~ctl_reg), // RQ19
      .i_d         ({i_operand_b_signed, i_operand_a_signed}), // RQ7
      .o_q         (sign_q),
      .o_reg       ()
   );

   assign o_shift_out_a = a_reg[17:0]; // RQ3 RQ4
   assign o_shift_out_b = b_reg[17:0]; // RQ3 RQ4

   // ------------------------------------------------------------------
   // Multiplier: two 9x9 lanes, one 18x18 or one 36x36
   // ------------------------------------------------------------------
   wire sa = sign_q[0];
   wire sb = sign_q[1];

   // Extending by one bit with the sign or a zero lets one signed
   // multiplier serve every signedness at full precision.
   wire signed [9:0]  ea0  = {sa & a_op[8],  a_op[8:0]};
   wire signed [9:0]  eb0  = {sb & b_op[8],  b_op[8:0]};
   wire signed [9:0]  ea1  = {sa & a_op[17], a_op[17:9]};
   wire signed [9:0]  eb1  = {sb & b_op[17], b_op[17:9]};
   wire signed [18:0] ea18 = {sa & a_op[17], a_op[17:0]};
   wire signed [18:0] eb18 = {sb & b_op[17], b_op[17:0]};
   wire signed [36:0] ea36 = {sa & a_op[35], a_op};
   wire signed [36:0] eb36 = {sb & b_op[35], b_op};
   wire signed [19:0] m9_0 = ea0 * eb0; // RQ20
   wire signed [19:0] m9_1 = ea1 * eb1; // RQ20
   wire signed [37:0] m18  = ea18 * eb18; // RQ10
   wire signed [73:0] m36  = ea36 * eb36; // RQ10

   wire        frac_ok = is_18 & sa & sb; // RQ11
   wire [35:0] p18_adj;
   wire        flag_c;

   dmfe_satrnd u_satrnd (
      .i_p      (m18[35:0]),
      .i_allow  (frac_ok),
      .i_sat_en (sat_en),
      .i_rnd_en (rnd_en),
      .o_p      (p18_adj),
      .o_flag   (flag_c)
   );

   // Narrow lanes keep their own sign so each product stays exact.
   wire [71:0] p_9  = {{18{m9_1[17] & (sa | sb)}}, m9_1[17:0],
                       {18{m9_0[17] & (sa | sb)}}, m9_0[17:0]};
   wire [71:0] p_18 = {{36{p18_adj[35] & (sa | sb)}}, p18_adj};
   wire [71:0] p_mx = is_9 ? p_9 : (is_36 ? m36[71:0] : p_18);
   wire        f_mx = is_18 ? flag_c : p_mx[0]; // RQ15
   wire        s_mx = sa | sb; // RQ8

   // ------------------------------------------------------------------
   // Optional pipeline register
   // ------------------------------------------------------------------
   wire [73:0] pipe_q;

   dmfe_inreg #(.WIDTH(74)) u_reg_pipe (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_clk_pulse (i_clk_pulse),
      .i_ena       (i_ena),
      .i_aclr      (i_aclr),
      .i_clk_sel   (sel_p[1:0]),
      .i_ena_sel   (sel_p[dmfe_pkg::SEL_ENA_OFS +: 2]),
      .i_aclr_sel  (sel_p[dmfe_pkg::SEL_ACLR_OFS +: 2]),
      .i_bypass    (pipe_byp), // RQ18
      .i_d         ({s_mx, f_mx, p_mx}),
      .o_q         (pipe_q),
      .o_reg       ()
   );

   assign o_product                = pipe_q[71:0];
   assign o_product_saturated_flag = pipe_q[72];
   assign o_product_signed         = pipe_q[73];

   // ------------------------------------------------------------------
   // Register read-back
   // ------------------------------------------------------------------
   wire [31:0] status_w = {29'h0000_0000, frac_ok & sat_en,
                           o_product_signed, o_product_saturated_flag};
   wire [31:0] rd_mux;
   wire        rd_ok;

   assign rd_ok  = (i_s_axi_araddr == dmfe_pkg::CTRL_OFS) |
                   (i_s_axi_araddr == dmfe_pkg::SEL_OFS) |
                   (i_s_axi_araddr == dmfe_pkg::STATUS_OFS);
   assign rd_mux = (i_s_axi_araddr == dmfe_pkg::CTRL_OFS) ? ctrl_r :
                   (i_s_axi_araddr == dmfe_pkg::SEL_OFS)  ? sel_r  :
                   (i_s_axi_araddr == dmfe_pkg::STATUS_OFS) ? status_w :
                   32'h0000_0000;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= dmfe_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_ok ? dmfe_pkg::RESP_OKAY : dmfe_pkg::RESP_SLVERR;
      end else if (i_s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_signed_out;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (pipe_byp && !ctl_reg) |-> (o_product_signed ==
         (i_operand_a_signed | i_operand_b_signed));
   endproperty
   a_signed_out: assert property (p_signed_out) // RQ8
      else $error("product sign type wrong");

   property p_no_shift36;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      is_36 |-> (a_in == i_data_a) && (b_in == i_data_b);
   endproperty
   a_no_shift36: assert property (p_no_shift36) // RQ6
      else $error("shift input used in 36x36");

   property p_sat_word;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (frac_ok && sat_en && (m18[35] != m18[34]) && !rnd_en) |->
         (p18_adj == 36'h3_ffff_fff9);
   endproperty
   a_sat_word: assert property (p_sat_word) // RQ14
      else $error("saturation value wrong");

   property p_rnd_low;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (frac_ok && rnd_en && !sat_en) |-> (p18_adj[15:0] == 16'h0000);
   endproperty
   a_rnd_low: assert property (p_rnd_low) // RQ16
      else $error("rounded low bits not cleared");

   property p_full_36;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (is_36 && !sa && !sb) |->
         (m36[71:0] == 72'(a_op) * 72'(b_op));
   endproperty
   a_full_36: assert property (p_full_36) // RQ10
      else $error("36x36 product truncated");

   property p_chain;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_clk_pulse[sel_a[1:0]] && i_ena[sel_a[3:2]] && src_a &&
       !i_aclr[sel_a[5:4]] && $stable(sel_r) && !i_aclr[sel_a[5:4]])
         ##1 !i_aclr[sel_a[5:4]] |->
         (o_shift_out_a == $past(i_shift_in_a));
   endproperty
   a_chain: assert property (p_chain) // RQ5
      else $error("chain shift missed");

   property p_bresp;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      do_write |=> o_s_axi_bvalid ##0
         (o_s_axi_bresp == ($past(wr_ok) ? 2'b00 : 2'b10));
   endproperty
   a_bresp: assert property (p_bresp)
      else $error("write response wrong");

   property p_rresp;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      ar_take |=> o_s_axi_rvalid && (o_s_axi_rdata == $past(rd_mux));
   endproperty
   a_rresp: assert property (p_rresp)
      else $error("read response wrong");

endmodule
`default_nettype wire

// *** pkg/dmfe_pkg.sv ***
`default_nettype none
package dmfe_pkg;

   // ------------------------------------------------------------------
   // Register map, byte addresses on the AXI4-Lite port
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] SEL_OFS     = 8'h04;
   localparam logic [7:0] STATUS_OFS  = 8'h08;

   localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
   localparam logic [31:0] SEL_RST    = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Control word fields
   // ------------------------------------------------------------------
   localparam int unsigned CTRL_SIZE_LSB   = 0;
   localparam int unsigned CTRL_A_BYP_BIT  = 2;
   localparam int unsigned CTRL_B_BYP_BIT  = 3;
   localparam int unsigned CTRL_CTL_REG    = 4;
   localparam int unsigned CTRL_PIPE_BYP   = 5;
   localparam int unsigned CTRL_SAT_BIT    = 6;
   localparam int unsigned CTRL_RND_BIT    = 7;
   localparam int unsigned CTRL_USED       = 8;

   // Select word: the A, B and pipeline registers each own clock, enable and clear selects; the sign register shares those of A.
   localparam int unsigned SEL_A_LSB       = 0;
   localparam int unsigned SEL_B_LSB       = 8;
   localparam int unsigned SEL_P_LSB       = 16;
   localparam int unsigned SEL_ENA_OFS     = 2;
   localparam int unsigned SEL_ACLR_OFS    = 4;

   // ------------------------------------------------------------------
   // Multiplier sizes and fixed-point constants
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      DMFE_SIZE_9  = 2'b00,
      DMFE_SIZE_18 = 2'b01,
      DMFE_SIZE_36 = 2'b10
   } dmfe_size_e;

   localparam logic [35:0] RND_ADD  = 36'h0_0004_0000;
   localparam logic [31:0] SAT_MAX  = 32'h7fff_ffff;
   localparam int unsigned RND_KEEP = 16;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
`default_nettype wire

// *** hdl/dmfe_inreg.sv ***
`timescale 1ns/100ps
`default_nettype none
module dmfe_inreg #(
   parameter int unsigned WIDTH = 18
) (
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   // Block clock, enable and clear lines with selects
   input  wire logic [3:0]       i_clk_pulse,
   input  wire logic [3:0]       i_ena,
   input  wire logic [3:0]       i_aclr,
   input  wire logic [1:0]       i_clk_sel,
   input  wire logic [1:0]       i_ena_sel,
   input  wire logic [1:0]       i_aclr_sel,
   // Data
   input  wire logic             i_bypass,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q,
   output logic      [WIDTH-1:0] o_reg
);

   logic [WIDTH-1:0] q_r;
   wire              load = i_clk_pulse[i_clk_sel] & i_ena[i_ena_sel];
   wire              clr  = i_aclr[i_aclr_sel];

   // The clear acts on the output at once, so no gated reset is needed.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) q_r <= '0;
      else if (clr) q_r <= '0;
      else if (load) q_r <= i_d;
   end

   assign o_reg = clr ? '0 : q_r; // RQ21
   assign o_q   = i_bypass ? i_d : o_reg; // RQ1

   property p_load;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (load && !clr) |=> (q_r == $past(i_d));
   endproperty
   a_load: assert property (p_load) else $error("register missed load"); // RQ2

   property p_clear;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      clr |-> (o_reg == '0) ##1 (q_r == '0);
   endproperty
   a_clear: assert property (p_clear) else $error("clear not applied"); // RQ21

endmodule
`default_nettype wire

// *** hdl/dmfe_satrnd.sv ***
`timescale 1ns/100ps
`default_nettype none
module dmfe_satrnd (
   // Product in 2.34 form
   input  wire logic [35:0] i_p,
   // Options
   input  wire logic        i_allow,
   input  wire logic        i_sat_en,
   input  wire logic        i_rnd_en,
   // Result
   output logic      [35:0] o_p,
   output logic             o_flag
);

   wire        do_rnd = i_allow & i_rnd_en;
   wire        do_sat = i_allow & i_sat_en;
   wire [35:0] sum    = i_p + dmfe_pkg::RND_ADD; // RQ16
   wire [35:0] r      = do_rnd ? {sum[35:dmfe_pkg::RND_KEEP],
                                  16'h0000} : i_p; // RQ16
   // Two sign copies that differ mean the value left the 1.31 range.
   wire        ovf    = r[35] ^ r[34]; // RQ13

   always_comb begin
      o_p = r;
      if (do_sat && ovf) begin
         o_p = {1'b0, dmfe_pkg::SAT_MAX, 3'h1}; // RQ14
      end else if (do_sat || do_rnd) begin
         o_p = {r[35:3], 3'h0}; // RQ17
      end
   end

   // The flag is the product's own lowest bit in every mode.
   assign o_flag = o_p[0]; // RQ15

endmodule
`default_nettype wire

// *** test/dmfe_fabric_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dmfe_fabric_model (
   // Raw or fractional operands
   input  wire logic        i_frac_en,
   input  wire logic [35:0] i_raw_a,
   input  wire logic [35:0] i_raw_b,
   input  wire logic        i_sign_a,
   input  wire logic        i_sign_b,
   // Towards the block
   output logic      [35:0] o_a,
   output logic      [35:0] o_b,
   output logic             o_sa,
   output logic             o_sb
);
   // A fraction rides in the top sixteen bits with two zero bits below.
   assign o_a = i_frac_en ? {{18{i_raw_a[15]}}, i_raw_a[15:0], 2'b00}
                          : i_raw_a;
   assign o_b = i_frac_en ? {{18{i_raw_b[15]}}, i_raw_b[15:0], 2'b00}
                          : i_raw_b;
   // One level per operand for the whole block; fractions need signs.
   assign o_sa = i_frac_en | i_sign_a;
   assign o_sb = i_frac_en | i_sign_b;
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clk = 0, rst_n = 0, aw_v = 0, w_v = 0, b_r = 0;
   logic        ar_v = 0, r_r = 0, fr = 0, sa = 0, sb = 0, src = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rd, rdata;
   logic [3:0]  ena = 4'hf, aclr = 4'h0;
   logic [35:0] ra = 0, rb = 0, da, db;
   logic        aw_r, w_r, b_v, ar_rd, r_v, psg, pflag, dsa, dsb;
   logic [1:0]  bresp, rresp, rs, bs;
   logic [17:0] so_a, so_b;
   logic [71:0] prod;
   int          errors = 0, total_checks = 0;

   always #4 clk = ~clk;

   dmfe_fabric_model fab (.i_frac_en(fr), .i_raw_a(ra), .i_raw_b(rb),
      .i_sign_a(sa), .i_sign_b(sb), .o_a(da), .o_b(db), .o_sa(dsa),
      .o_sb(dsb));
   dmfe_top dut (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(aw_v),
      .o_s_axi_awready(aw_r), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(w_v), .o_s_axi_wready(w_r),
      .o_s_axi_bresp(bresp), .o_s_axi_bvalid(b_v), .i_s_axi_bready(b_r),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(ar_v),
      .o_s_axi_arready(ar_rd), .o_s_axi_rdata(rdata),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(r_v), .i_s_axi_rready(r_r),
      .i_clk_pulse(4'hf), .i_ena(ena), .i_aclr(aclr), .i_data_a(da),
      .i_data_b(db), .i_operand_a_signed(dsa), .i_operand_b_signed(dsb),
      .i_operand_a_source_select(src), .i_operand_b_source_select(src),
      .i_shift_in_a(18'h155), .i_shift_in_b(18'h0aa),
      .o_shift_out_a(so_a), .o_shift_out_b(so_b), .o_product(prod),
      .o_product_signed(psg), .o_product_saturated_flag(pflag));

   // -------------------------------------------------------------------
   // Bus and stimulus tasks
   // -------------------------------------------------------------------
   task automatic chk(input string n, input logic [71:0] s, e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask

   // Readies are sampled mid-cycle, so the release lands after the edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, hb;
      pa = 1;
      pw = 1;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      aw_v <= 1;
      w_v <= 1;
      b_r <= 1;
      do begin
         @(negedge clk);
         if (aw_r) pa = 0;
         if (w_r) pw = 0;
         hb = b_v;
         bs = bresp;
         @(posedge clk);
         aw_v <= pa;
         w_v <= pw;
      end while (!hb);
      b_r <= 0;
   endtask

   task automatic rdr(input logic [7:0] a);
      logic pa, hr;
      pa = 1;
      @(posedge clk);
      araddr <= a;
      ar_v <= 1;
      r_r <= 1;
      do begin
         @(negedge clk);
         if (ar_rd) pa = 0;
         hr = r_v;
         rd = rdata;
         rs = rresp;
         @(posedge clk);
         ar_v <= pa;
      end while (!hr);
      r_r <= 0;
   endtask

   task automatic op(input logic [35:0] a, b, input logic s_a, s_b, f,
                     input logic c, input int n);
      @(posedge clk);
      ra <= a;
      rb <= b;
      sa <= s_a;
      sb <= s_b;
      fr <= f;
      src <= c;
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #200000;
      errors++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1;
      rdr(8'h00);
      chk("ctrl", rd, 72'h1);
      rdr(8'h0c);
      chk("resp", rs, 72'h2);
      wr(8'h0c, 32'h22);
      chk("bres", bs, 72'h2);
      wr(8'h00, 32'h31);
      chk("bok", bs, 72'h0);
      op(36'h3ffff, 36'h3ffff, 0, 0, 0, 0, 3);
      chk("u18", prod, 72'hf_fff8_0001);
      chk("usg", psg, 72'h0);
      // Registered signs must still show the old level before a load.
      op(36'h3fffd, 36'h5, 1, 0, 0, 0, 0);
      chk("lag", psg, 72'h0);
      op(36'h3fffd, 36'h5, 1, 0, 0, 0, 3);
      chk("s18", prod, 72'hff_ffff_ffff_ffff_fff1);
      chk("ssg", psg, 72'h1);
      op(36'h0, 36'h2, 0, 0, 0, 1, 3);
      chk("sha", so_a, 72'h155);
      chk("shp", prod, 72'he272);
      wr(8'h00, 32'h22);
      op(36'h8_0000_0001, 36'h3, 0, 0, 0, 1, 3);
      chk("m36", prod, 72'h18_0000_0003);
      chk("sh36", so_a, 72'h1);
      wr(8'h00, 32'h20);
      op(36'h602, 36'h805, 0, 0, 0, 0, 3);
      chk("m9", prod, {18'd0, 18'd12, 18'd0, 18'd10});
      wr(8'h00, 32'h61);
      op(36'h8000, 36'h8000, 0, 0, 1, 0, 3);
      chk("sat", prod[35:0], 72'h3_ffff_fff9);
      chk("satf", pflag, 72'h1);
      rdr(8'h08);
      chk("stat", rd, 72'h7);
      op(36'h4000, 36'h4000, 0, 0, 1, 0, 3);
      chk("nsat", prod[35:0], 72'h1_0000_0000);
      chk("nsatf", pflag, 72'h0);
      op(36'h20000, 36'h20000, 0, 0, 0, 0, 3);
      chk("usat", prod[35:0], 72'h4_0000_0000);
      wr(8'h00, 32'ha1);
      op(36'h0800, 36'h0001, 0, 0, 1, 0, 3);
      chk("rnd", prod[35:0], 72'h4_0000);
      wr(8'h00, 32'h01);
      op(36'h7, 36'h6, 0, 0, 0, 0, 1);
      chk("pip1", prod, 72'h8000);
      @(posedge clk);
      #1;
      chk("pip2", prod, 72'd42);
      wr(8'h00, 32'h2d);
      @(posedge clk);
      ena <= 4'h0;
      op(36'h9, 36'h9, 0, 0, 0, 0, 0);
      chk("byp", prod, 72'd81);
      wr(8'h00, 32'h21);
      op(36'h2, 36'h2, 0, 0, 0, 0, 3);
      chk("hold", prod, 72'd42);
      @(posedge clk);
      ena <= 4'hf;
      aclr <= 4'h1;
      #1;
      chk("clr", so_a, 72'h0);
      wr(8'h04, 32'h10);
      #1;
      chk("sela", so_a, 72'h2);
      chk("clrb", so_b, 72'h0);
      summarize();
   end
endmodule
`default_nettype wire
